// *** hw/ascr_defs.vh ***
// Constants for the serial configuration register bank
`ifndef ASCR_DEFS_VH
`define ASCR_DEFS_VH

// Word layout
`define ASCR_WORD_BITS      5'd16
`define ASCR_CNT_W          5
`define ASCR_ADDR_MSB       15
`define ASCR_ADDR_LSB       8
`define ASCR_DATA_MSB       7
`define ASCR_DATA_LSB       0

// Register addresses
`define ASCR_A_NOISE        8'h5d
`define ASCR_A_CLKPOS       8'h62
`define ASCR_A_PFS          8'h63
`define ASCR_A_TPSEL        8'h65
`define ASCR_A_GAIN         8'h68
`define ASCR_A_PATLO        8'h69
`define ASCR_A_PATHI        8'h6a
`define ASCR_A_IFSEL        8'h6c
`define ASCR_A_REF          8'h6d
`define ASCR_A_SWRST        8'h6e
`define ASCR_A_TERM         8'h7e
`define ASCR_A_BOOST        8'h7f

// Reset values
`define ASCR_RST_ZERO       8'h00
`define ASCR_RST_CLKPOS     5'h01

// Field positions
`define ASCR_B_NOISE        0
`define ASCR_F_CLKPOS_MSB   4
`define ASCR_F_CLKPOS_LSB   0
`define ASCR_B_STANDBY      7
`define ASCR_B_FORMAT       3
`define ASCR_B_LOWSPEED     0
`define ASCR_F_TP_MSB       7
`define ASCR_F_TP_LSB       5
`define ASCR_F_GAIN_MSB     3
`define ASCR_F_GAIN_LSB     0
`define ASCR_F_IF_MSB       4
`define ASCR_F_IF_LSB       3
`define ASCR_B_REF          4
`define ASCR_B_SWRST        0
`define ASCR_F_DTERM_MSB    7
`define ASCR_F_DTERM_LSB    5
`define ASCR_F_CTERM_MSB    4
`define ASCR_F_CTERM_LSB    2
`define ASCR_F_CURR_MSB     1
`define ASCR_F_CURR_LSB     0
`define ASCR_F_BOOST_MSB    7
`define ASCR_F_BOOST_LSB    6

`endif

// *** hw/ascr_sync.v ***
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
module ascr_sync (
  sys_clk,
  rst_n,
  async_in,
  sync_out
);
  input  wire sys_clk;   // System clock
  input  wire rst_n;     // Async reset, active low
  input  wire async_in;  // Level from outside the clock domain
  output reg  sync_out;  // Synchronised level

  reg meta_reg;          // First stage, read only by second stage

  // Two flops; reset to a constant idle value of zero
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// *** hw/ascr_regbank.v ***
// Serially programmed configuration register bank of a sampling converter
`timescale 1ns/100ps
`include "ascr_defs.vh"
module ascr_regbank (
  sys_clk,
  rst_n,
  hw_reset,
  serial_clk,
  serial_select_n,
  serial_in_line,
  low_band_noise_cancel,
  clock_placement,
  standby,
  output_number_format,
  low_speed_mode,
  test_pattern_mode,
  custom_pattern,
  fine_gain,
  output_interface,
  reference_external,
  data_termination,
  clock_termination,
  driver_current,
  current_boost,
  word_done
);
  // Clock, resets and the host serial port
  input  wire        sys_clk;               // 25 MHz system clock
  input  wire        rst_n;                 // Async reset, active low
  input  wire        hw_reset;              // Reset pin, active high, async
  input  wire        serial_clk;            // Shift clock from host
  input  wire        serial_select_n;       // Select, active low
  input  wire        serial_in_line;        // Serial data in
  // Stored configuration fields
  output reg         low_band_noise_cancel; // Noise suppression enable
  output reg  [4:0]  clock_placement;       // Output clock placement code
  output reg         standby;               // Global power-down
  output reg         output_number_format;  // 0 twos complement, 1 offset
  output reg         low_speed_mode;        // Low sampling rate mode
  output reg  [2:0]  test_pattern_mode;     // Test pattern select
  output reg  [15:0] custom_pattern;        // Custom test pattern word
  output reg  [3:0]  fine_gain;             // Fine gain code
  output reg  [1:0]  output_interface;      // Output interface select
  output reg         reference_external;    // 1 external reference
  output reg  [2:0]  data_termination;      // Data output termination
  output reg  [2:0]  clock_termination;     // Clock output termination
  output reg  [1:0]  driver_current;        // Driver current code
  output reg  [1:0]  current_boost;         // Current doubling code
  // Status
  output reg         word_done;             // Pulse: a word was taken

  // Timing: pin edges reach the logic two clocks late, a fall is seen
  // one clock after that and the word lands one clock later again, so
  // outputs move four clocks after the closing shift clock fall.
  // Limitation: each shift clock level must stand for at least three
  // system clocks, or an edge can slip between synchroniser samples.
  // Trade-off: oversampling the shift clock costs latency but keeps a
  // single clock domain and no hold-time race on the data line.

  // Synchronised pin levels
  wire sclk_s;     // Shift clock
  wire sel_act_s;  // Select, high while the host selects us
  wire sdi_s;      // Serial data
  wire hwrst_s;    // Reset pin, high while asserted

  // Shift clock; resets to its parked low level, so no false edge
  ascr_sync u_sync_sclk (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (serial_clk),
    .sync_out (sclk_s)
  );

  // Select pin inverted first, so reset reads as deselected
  ascr_sync u_sync_sel (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (~serial_select_n),
    .sync_out (sel_act_s)
  );

  // Data line; read only on a detected fall, long after it settled
  ascr_sync u_sync_sdi (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (serial_in_line),
    .sync_out (sdi_s)
  );

  // Reset pin; a pulse shorter than two clocks may be missed
  ascr_sync u_sync_rst (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (hw_reset),
    .sync_out (hwrst_s)
  );

  // Synchronised select, high while a frame is open
  wire selected = sel_act_s;

  // Shifter state
  reg                    sclk_d_reg;   // Previous synced shift clock
  reg [15:0]             shift_reg;    // Incoming word
  reg [`ASCR_CNT_W-1:0]  count_reg;    // Bits taken in this word
  reg                    load_reg;     // Full word ready to apply
  reg [`ASCR_CNT_W-1:0]  count_next;   // Next bit count
  reg                    load_next;    // Next word strobe

  // Falling edge of the shift clock while selected
  wire fall = sclk_d_reg & ~sclk_s & selected;
  wire [15:0] shift_next = {shift_reg[14:0], sdi_s};
  wire [7:0]  w_addr = shift_reg[`ASCR_ADDR_MSB:`ASCR_ADDR_LSB];
  wire [7:0]  w_data = shift_reg[`ASCR_DATA_MSB:`ASCR_DATA_LSB];

  // Bit counting; every 16th fall closes a word and restarts the count.
  // Deselect also restarts it, so the bits of a cut frame are dropped
  // and the next frame starts aligned on a fresh address byte.
  always @* begin
    count_next = count_reg;
    load_next  = 1'b0;
    if (!selected) begin
      // Frame closed: forget any partial word
      count_next = {`ASCR_CNT_W{1'b0}};
    end else if (fall) begin
      if (count_reg == `ASCR_WORD_BITS - 5'd1) begin
        // Last bit of the word: hand it over
        count_next = {`ASCR_CNT_W{1'b0}};
        load_next  = 1'b1;
      end else begin
        // Still collecting address or data bits
        count_next = count_reg + 5'd1;
      end
    end
  end

  // Shifter flops; the word stays in shift_reg while it is applied
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b0;
      shift_reg  <= 16'h0000;
      count_reg  <= {`ASCR_CNT_W{1'b0}};
      load_reg   <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      count_reg  <= count_next;
      load_reg   <= load_next;
      if (fall) begin
        // Address byte first, MSB first
        shift_reg <= shift_next;
      end
    end
  end

  // Software reset strobe from a word to the reset register
  // Limitation: the strobe lasts one cycle and nothing is kept at that
  // address, so the bit clears itself with no second write
  wire sw_reset = load_reg && (w_addr == `ASCR_A_SWRST) &&
                  w_data[`ASCR_B_SWRST];
  wire clear_all = hwrst_s | sw_reset;

  // Register bank; unused bits are not stored since the host zeroes them.
  // A clear wins over a word landing in the same cycle, so a reset word
  // or the pin never leaves a half-applied configuration behind.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_band_noise_cancel <= 1'b0;
      clock_placement       <= `ASCR_RST_CLKPOS;
      // Power, format and speed controls
      standby               <= 1'b0;
      output_number_format  <= 1'b0;
      low_speed_mode        <= 1'b0;
      // Pattern and gain controls
      test_pattern_mode     <= 3'h0;
      custom_pattern        <= 16'h0000;
      fine_gain             <= 4'h0;
      // Interface and reference
      output_interface      <= 2'h0;
      reference_external    <= 1'b0;
      // Driver termination and current
      data_termination      <= 3'h0;
      clock_termination     <= 3'h0;
      driver_current        <= 2'h0;
      current_boost         <= 2'h0;
      word_done             <= 1'b0;
    end else begin
      // Strobe lines up with the outputs that the word changes
      word_done <= load_reg;
      if (clear_all) begin
        // Hardware pin or self-clearing software reset
        low_band_noise_cancel <= 1'b0;
        clock_placement       <= `ASCR_RST_CLKPOS;
        // Power, format and speed controls
        standby               <= 1'b0;
        output_number_format  <= 1'b0;
        low_speed_mode        <= 1'b0;
        // Pattern and gain controls
        test_pattern_mode     <= 3'h0;
        custom_pattern        <= 16'h0000;
        fine_gain             <= 4'h0;
        // Interface and reference
        output_interface      <= 2'h0;
        reference_external    <= 1'b0;
        // Driver termination and current
        data_termination      <= 3'h0;
        clock_termination     <= 3'h0;
        driver_current        <= 2'h0;
        current_boost         <= 2'h0;
      end else if (load_reg) begin
        // All fields of one register update together
        case (w_addr)
          // Low-band noise suppression switch
          `ASCR_A_NOISE: begin
            low_band_noise_cancel <= w_data[`ASCR_B_NOISE];
          end

          // Output clock placement code
          `ASCR_A_CLKPOS: begin
            // Edge shifts per code are applied by the output clock logic
            clock_placement <=
              w_data[`ASCR_F_CLKPOS_MSB:`ASCR_F_CLKPOS_LSB];
          end

          // Standby, number format and low speed share one register
          `ASCR_A_PFS: begin
            standby              <= w_data[`ASCR_B_STANDBY];
            output_number_format <= w_data[`ASCR_B_FORMAT];
            low_speed_mode       <= w_data[`ASCR_B_LOWSPEED];
          end

          // Test pattern selection
          `ASCR_A_TPSEL: begin
            test_pattern_mode <= w_data[`ASCR_F_TP_MSB:`ASCR_F_TP_LSB];
          end

          // Fine gain code
          `ASCR_A_GAIN: begin
            fine_gain <= w_data[`ASCR_F_GAIN_MSB:`ASCR_F_GAIN_LSB];
          end

          // Custom pattern, lower byte
          `ASCR_A_PATLO: begin
            custom_pattern[7:0] <= w_data;
          end

          // Custom pattern, upper byte
          `ASCR_A_PATHI: begin
            custom_pattern[15:8] <= w_data;
          end

          // Output interface selection
          `ASCR_A_IFSEL: begin
            output_interface <= w_data[`ASCR_F_IF_MSB:`ASCR_F_IF_LSB];
          end

          // Reference mode
          `ASCR_A_REF: begin
            reference_external <= w_data[`ASCR_B_REF];
          end

          // Termination and driver current, all in one write
          `ASCR_A_TERM: begin
            data_termination  <= w_data[`ASCR_F_DTERM_MSB:`ASCR_F_DTERM_LSB];
            clock_termination <= w_data[`ASCR_F_CTERM_MSB:`ASCR_F_CTERM_LSB];
            driver_current    <= w_data[`ASCR_F_CURR_MSB:`ASCR_F_CURR_LSB];
          end

          // Current doubling code
          `ASCR_A_BOOST: begin
            current_boost <= w_data[`ASCR_F_BOOST_MSB:`ASCR_F_BOOST_LSB];
          end
          default: begin
            // Unmapped address: nothing changes
            // The reset address lands here too; its clear is handled above
          end
        endcase
      end
    end
  end
endmodule

// *** test/ascr_regbank_chk.sv ***
// Assertion checker for the configuration register bank
`timescale 1ns/100ps
module ascr_regbank_chk (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        hw_reset,
  input wire        low_band_noise_cancel,
  input wire [4:0]  clock_placement,
  input wire        standby,
  input wire        output_number_format,
  input wire        low_speed_mode,
  input wire [15:0] custom_pattern,
  input wire        reference_external,
  input wire [2:0]  data_termination,
  input wire [2:0]  clock_termination,
  input wire [1:0]  driver_current,
  input wire        word_done
);
  reg  [5:0] hw_hist;                   // Recent pin reset samples
  wire       quiet = ~|hw_hist & ~hw_reset; // No pin clear in flight
  // Pin clear lands late through its synchroniser, so remember it a while
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) hw_hist <= 6'h00;
    else hw_hist <= {hw_hist[4:0], hw_reset};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_idle; quiet && !word_done; endsequence
  sequence s_pin_hold; hw_reset [*6]; endsequence
  property p_noise_hold; s_idle |-> $stable(low_band_noise_cancel); endproperty
  property p_place_hold; s_idle |-> $stable(clock_placement); endproperty
  property p_pfs_hold;
    s_idle |-> $stable({standby, output_number_format, low_speed_mode});
  endproperty
  property p_pat_hold; s_idle |-> $stable(custom_pattern); endproperty
  property p_ref_hold; s_idle |-> $stable(reference_external); endproperty
  property p_term_hold;
    s_idle |-> $stable({data_termination, clock_termination, driver_current});
  endproperty
  property p_done_pulse; word_done |=> !word_done; endproperty
  property p_pin_clear;
    s_pin_hold |-> clock_placement == 5'h01 && custom_pattern == 16'h0000 && !standby;
  endproperty
  a_noise_hold: assert property (p_noise_hold) else $error("noise bit moved");
  a_place_hold: assert property (p_place_hold) else $error("placement moved");
  a_pfs_hold: assert property (p_pfs_hold) else $error("power bits moved");
  a_pat_hold: assert property (p_pat_hold) else $error("pattern moved");
  a_ref_hold: assert property (p_ref_hold) else $error("reference moved");
  a_term_hold: assert property (p_term_hold) else $error("driver moved");
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  a_pin_clear: assert property (p_pin_clear) else $error("pin clear missed");
endmodule

bind ascr_regbank ascr_regbank_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .hw_reset(hw_reset), .low_band_noise_cancel(low_band_noise_cancel),
  .clock_placement(clock_placement), .standby(standby),
  .output_number_format(output_number_format), .low_speed_mode(low_speed_mode),
  .custom_pattern(custom_pattern), .reference_external(reference_external),
  .data_termination(data_termination), .clock_termination(clock_termination),
  .driver_current(driver_current), .word_done(word_done));

// *** test/ascr_host.sv ***
// Host model for the three-wire configuration port
`timescale 1ns/100ps
module ascr_host (
  input  wire sys_clk,
  output reg  serial_clk,
  output reg  serial_select_n,
  output reg  serial_in_line
);
  integer i; // Bit index
  // Port idle: deselected, shift clock parked low
  initial begin
    serial_clk = 1'b0;
    serial_select_n = 1'b1;
    serial_in_line = 1'b0;
  end
  // A third of the 480 ns shift period
  task tick;
    repeat (4) @(posedge sys_clk);
  endtask
  // One word, address byte then data byte, MSB first
  task send(input [15:0] w);
    send_part(w, 16);
  endtask
  // Leading bits of a word; fewer than 16 leaves the frame cut short
  task send_part(input [15:0] w, input integer nb);
    begin
      @(posedge sys_clk);
      serial_select_n <= 1'b0;
      for (i = 15; i >= 16 - nb; i = i - 1) begin
        serial_in_line <= w[i];
        tick;
        serial_clk <= 1'b1;
        tick;
        serial_clk <= 1'b0;
        tick;
      end
    end
  endtask
  // Released data line shows no stale bit
  task release_port;
    begin
      @(posedge sys_clk);
      serial_select_n <= 1'b1;
      serial_in_line <= ~serial_in_line;
      tick;
    end
  endtask
endmodule

// *** test/adc_serial_config_registers_test.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
module adc_serial_config_registers_test;
  reg         sys_clk, rst_n, hw_reset;       // Bench driven
  wire        serial_clk, serial_select_n, serial_in_line;
  wire        low_band_noise_cancel, standby, output_number_format;
  wire        low_speed_mode, reference_external, word_done;
  wire [4:0]  clock_placement;
  wire [2:0]  test_pattern_mode, data_termination, clock_termination;
  wire [15:0] custom_pattern;
  wire [3:0]  fine_gain;
  wire [1:0]  output_interface, driver_current, current_boost;
  wire [44:0] all_out = {low_band_noise_cancel, clock_placement, standby,
    output_number_format, low_speed_mode, test_pattern_mode, custom_pattern, fine_gain,
    output_interface, reference_external, data_termination, clock_termination,
    driver_current, current_boost};
  localparam [44:0] RST_ALL = 45'h0080_0000_0000; // Only placement is nonzero
  // State after the field writes and the placement walk
  localparam [44:0] EXP_MID = {1'b1, 5'h1b, 3'h2, 3'h5, 16'h1234, 4'h9, 2'h3,
    1'b1, 8'hb6, 2'h3};
  integer miscompares = 0, check_count = 0, n, k;
  reg [4:0] codes [0:5]; // Placement codes to walk
  ascr_host host (.sys_clk(sys_clk), .serial_clk(serial_clk),
    .serial_select_n(serial_select_n), .serial_in_line(serial_in_line));
  ascr_regbank uut (.sys_clk(sys_clk), .rst_n(rst_n), .hw_reset(hw_reset),
    .serial_clk(serial_clk), .serial_select_n(serial_select_n),
    .serial_in_line(serial_in_line), .low_band_noise_cancel(low_band_noise_cancel),
    .clock_placement(clock_placement), .standby(standby),
    .output_number_format(output_number_format), .low_speed_mode(low_speed_mode),
    .test_pattern_mode(test_pattern_mode), .custom_pattern(custom_pattern),
    .fine_gain(fine_gain), .output_interface(output_interface),
    .reference_external(reference_external), .data_termination(data_termination),
    .clock_termination(clock_termination), .driver_current(driver_current),
    .current_boost(current_boost), .word_done(word_done));
  task chk(input [44:0] got, input [44:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Write one word, then wait a bounded time for the done pulse
  task wr(input [7:0] a, input [7:0] d);
    begin
      host.send({a, d});
      #1; // Done pulse may already stand as the send returns
      n = 0;
      while (word_done !== 1'b1 && n < 20) begin
        @(posedge sys_clk);
        #1;
        n = n + 1;
      end
      chk(word_done, 1'h1);
      host.release_port;
    end
  endtask
  task t_fields;
    wr(8'h63, 8'h89);
    chk({standby, output_number_format, low_speed_mode}, 3'h7);
    wr(8'h63, 8'h08);
    chk({standby, output_number_format, low_speed_mode}, 3'h2);
    wr(8'h5d, 8'h01);
    chk(low_band_noise_cancel, 1'h1);
    wr(8'h69, 8'h34);
    wr(8'h6a, 8'h12);
    chk(custom_pattern, 16'h1234);
    wr(8'h6d, 8'h10);
    chk(reference_external, 1'h1);
    wr(8'h7e, 8'hb6);
    chk({data_termination, clock_termination, driver_current}, 8'hb6);
    wr(8'h65, 8'ha0);
    wr(8'h68, 8'h09);
    wr(8'h6c, 8'h18);
    wr(8'h7f, 8'hc0);
    chk({test_pattern_mode, fine_gain, output_interface, current_boost}, 11'h059f);
  endtask
  // Every documented placement code lands whole in the field
  task t_place;
    for (k = 0; k < 6; k = k + 1) begin
      wr(8'h62, {3'h0, codes[k]});
      chk(clock_placement, codes[k]);
    end
  endtask
  task t_unmapped;
    wr(8'h60, 8'hff);
    chk(all_out, EXP_MID);
  endtask
  // Cut frame is dropped; later words in one select land in order
  task t_cut;
    begin
      host.send_part(16'h5d00, 8);
      host.release_port;
      chk(all_out, EXP_MID);
      wr(8'h60, 8'h00);
      chk(all_out, EXP_MID);
      host.send(16'h6d00);
      wr(8'h5d, 8'h00);
      chk({low_band_noise_cancel, reference_external}, 2'h0);
    end
  endtask
  task t_swrst;
    wr(8'h6e, 8'h01);
    chk(all_out, RST_ALL);
  endtask
  // Pin reset long enough for its synchroniser, then settle
  task t_hwrst;
    wr(8'h69, 8'hff);
    @(posedge sys_clk);
    hw_reset <= 1'b1;
    repeat (8) @(posedge sys_clk);
    hw_reset <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk(all_out, RST_ALL);
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    hw_reset = 1'b0;
    codes[0] = 5'h03; codes[1] = 5'h05; codes[2] = 5'h07;
    codes[3] = 5'h0b; codes[4] = 5'h13; codes[5] = 5'h1b;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(all_out, RST_ALL);
    t_fields;
    t_place;
    t_unmapped;
    t_cut;
    t_swrst;
    t_hwrst;
    tally_and_finish;
  end
  // Watchdog well beyond the expected run of about 200 us
  initial begin
    #2000000;
    miscompares = miscompares + 1;
    tally_and_finish;
  end
endmodule
